// ---- shared/wwdt_consts.vh ----
`ifndef WWDT_CONSTS_VH
`define WWDT_CONSTS_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define WWDT_IDX_CTRL 6'h00
`define WWDT_IDX_STATUS 6'h01
`define WWDT_IDX_GUARD 6'h02

// ----------------------------------------
// Field positions
// ----------------------------------------
`define WWDT_PER_LSB 0
`define WWDT_PER_MSB 3
`define WWDT_WIN_LSB 4
`define WWDT_WIN_MSB 7
`define WWDT_LOCK_BIT 7
`define WWDT_PEND_BIT 0

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define WWDT_CTRL_RST 8'h00
`define WWDT_LOCK_RST 1'h0
`define WWDT_CODE_OFF 4'h0
`define WWDT_CODE_MAX 4'hB

// ----------------------------------------
// Timing counts
// ----------------------------------------
`define WWDT_GUARD_CYCLES 3'h4
`define WWDT_SYNC_TICKS 2'h3

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define WWDT_RESP_OKAY 2'h0
`define WWDT_RESP_SLVERR 2'h2

`endif

// ---- hw/wwdt_tick_sync.v ----
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_consts.vh"

module wwdt_tick_sync
#(
	parameter [1:0] TICKS = `WWDT_SYNC_TICKS
)
(
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Request and watchdog tick
	input wire start,
	input wire tick,
	// Progress
	output reg busy,
	output reg done
);

reg [1:0] cnt_reg;

// ----------------------------------------
// Transfer into the watchdog tick domain
// ----------------------------------------
always @(posedge clk_sys)
begin
	if (rst)
	begin
		busy <= 1'b0;
		done <= 1'b0;
		cnt_reg <= 2'h0;
	end
	else
	begin
		done <= 1'b0;
		if (!busy)
		begin
			if (start)
			begin
				busy <= 1'b1;
				cnt_reg <= 2'h0;
			end
		end
		else if (tick)
		begin
			if (cnt_reg == TICKS - 2'h1)
			begin
				busy <= 1'b0;
				done <= 1'b1;
			end
			else
			begin
				cnt_reg <= cnt_reg + 2'h1;
			end
		end
	end
end

endmodule // wwdt_tick_sync

`default_nettype wire

// ---- hw/wwdt_top.v ----
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_consts.vh"

// Behaviour
// - Once enabled, missing a clear before timeout requests a system reset.
// - Non-zero timeout code enables the watchdog; zero disables it.
// - Eleven timeout codes select 8 to 8192 watchdog clock periods.
// - Every accepted clear outside the closed period restarts the count.
// - Closed-slot code zero means Normal mode, non-zero means Window mode.
// - In Window mode a clear during the closed period requests reset.
// - Open period follows closed period; total timeout is their sum.
// - After enabling Window mode, first closed period starts at first clear.
// - Clear takes two to three watchdog ticks; clears meanwhile are ignored.
// - Counting continues in run-time debug but stops while CPU is halted.
// - A debug halt resets the watchdog counter.
// - Resuming from halt in Window mode runs one Normal timeout first.
// - While locked, timeout and closed-slot fields cannot change.
// - Lock is set by software or by an enabled fuse load; cleared only in debug mode.
// - Control field reset value comes from the boot configuration fuse.
// - Loading an enabled configuration from the fuse sets the lock.
// - Protected writes accepted only within four cycles after the guard key.
// - Protected writes without unlock complete but change nothing.
// - Control writes are transferred to the tick domain with pending flag set.
// - Counting runs on the 1 kHz watchdog oscillator, not the system clock.
// - Watchdog keeps operating only while both its oscillator and the system clock run.
// - Closed-slot bits 7:4, timeout bits 3:0; codes 1 to B double.
// - Pending flag clears itself when the transfer has finished.
module wwdt_top
#(
	parameter ADDR_W = 8,
	parameter [7:0] UNLOCK_KEY = 8'hA5 // io_unlock_key, arbitrary value
)
(
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Watchdog oscillator and system hooks
	input wire dog_osc_clk,
	input wire [7:0] boot_cfg_fuse,
	input wire dog_clear_instr,
	input wire dbg_mode,
	input wire dbg_halt,
	output reg dog_reset_req,
	// AXI4-Lite write address
	input wire [ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// AXI4-Lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// AXI4-Lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address
	input wire [ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// AXI4-Lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready
);

// ----------------------------------------
// States
// ----------------------------------------
localparam [3:0] ST_OFF = 4'h1;
localparam [3:0] ST_NORM = 4'h2;
localparam [3:0] ST_CLOSED = 4'h4;
localparam [3:0] ST_OPEN = 4'h8;

// ----------------------------------------
// Functions
// ----------------------------------------
function [13:0] wwdt_last;
	input [3:0] code;
	begin
		case (code)
			4'h1: wwdt_last = 14'h0007;
			4'h2: wwdt_last = 14'h000F;
			4'h3: wwdt_last = 14'h001F;
			4'h4: wwdt_last = 14'h003F;
			4'h5: wwdt_last = 14'h007F;
			4'h6: wwdt_last = 14'h00FF;
			4'h7: wwdt_last = 14'h01FF;
			4'h8: wwdt_last = 14'h03FF;
			4'h9: wwdt_last = 14'h07FF;
			4'hA: wwdt_last = 14'h0FFF;
			default: wwdt_last = 14'h1FFF;
		endcase
	end
endfunction

function mapped;
	input [5:0] idx;
	begin
		mapped = (idx == `WWDT_IDX_CTRL) || (idx == `WWDT_IDX_STATUS) ||
			(idx == `WWDT_IDX_GUARD);
	end
endfunction

// ----------------------------------------
// Declarations
// ----------------------------------------
reg osc_meta_reg;
reg osc_sync_reg;
reg osc_prev_reg;
reg aw_have_reg;
reg [5:0] aw_idx_reg;
reg w_have_reg;
reg [7:0] w_data_reg;
reg w_strb_reg;
reg [7:0] ctrl_reg;
reg lock_reg;
reg [2:0] guard_cnt_reg;
reg boot_done_reg;
reg [3:0] act_period_reg;
reg [3:0] act_window_reg;
reg [3:0] state_reg;
reg [13:0] cnt_reg;
reg [5:0] ar_idx;
reg [7:0] rd_byte;
wire tick;
wire wr_fire;
wire wr_ok;
wire prot_ok;
wire ctrl_wr;
wire cfg_busy;
wire cfg_done;
wire clr_busy;
wire clr_done;
wire [13:0] last_cnt;

assign tick = osc_sync_reg & ~osc_prev_reg;
assign wr_fire = aw_have_reg & w_have_reg & ~s_axi_bvalid;
assign wr_ok = wr_fire & w_strb_reg;
assign prot_ok = (guard_cnt_reg != 3'h0);
assign ctrl_wr = wr_ok & (aw_idx_reg == `WWDT_IDX_CTRL) & prot_ok & ~lock_reg &
	~cfg_busy & boot_done_reg;
assign last_cnt = (state_reg == ST_CLOSED) ? wwdt_last(act_window_reg) :
	wwdt_last(act_period_reg);

// ----------------------------------------
// Watchdog oscillator edge detection
// ----------------------------------------
always @(posedge clk_sys)
begin
	if (rst)
	begin
		osc_meta_reg <= 1'b0;
		osc_sync_reg <= 1'b0;
		osc_prev_reg <= 1'b0;
	end
	else
	begin
		osc_meta_reg <= dog_osc_clk;
		osc_sync_reg <= osc_meta_reg;
		osc_prev_reg <= osc_sync_reg;
	end
end

// ----------------------------------------
// Transfers into the tick domain
// ----------------------------------------
wwdt_tick_sync u_cfg_sync
(
	.clk_sys(clk_sys),
	.rst(rst),
	.start(ctrl_wr),
	.tick(tick),
	.busy(cfg_busy),
	.done(cfg_done)
);

wwdt_tick_sync u_clr_sync
(
	.clk_sys(clk_sys),
	.rst(rst),
	.start(dog_clear_instr & ~clr_busy),
	.tick(tick),
	.busy(clr_busy),
	.done(clr_done)
);

// ----------------------------------------
// AXI4-Lite write channel
// ----------------------------------------
always @(posedge clk_sys)
begin
	if (rst)
	begin
		aw_have_reg <= 1'b0;
		aw_idx_reg <= 6'h00;
		w_have_reg <= 1'b0;
		w_data_reg <= 8'h00;
		w_strb_reg <= 1'b0;
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `WWDT_RESP_OKAY;
	end
	else
	begin
		if (s_axi_awvalid && s_axi_awready)
		begin
			aw_have_reg <= 1'b1;
			aw_idx_reg <= s_axi_awaddr[7:2];
			s_axi_awready <= 1'b0;
		end
		else if (!aw_have_reg && !s_axi_bvalid)
		begin
			s_axi_awready <= 1'b1;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			w_have_reg <= 1'b1;
			w_data_reg <= s_axi_wdata[7:0];
			w_strb_reg <= s_axi_wstrb[0];
			s_axi_wready <= 1'b0;
		end
		else if (!w_have_reg && !s_axi_bvalid)
		begin
			s_axi_wready <= 1'b1;
		end
		if (wr_fire)
		begin
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= mapped(aw_idx_reg) ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
		end
		else if (s_axi_bvalid && s_axi_bready)
		begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// ----------------------------------------
// AXI4-Lite read channel
// ----------------------------------------
always @*
begin
	ar_idx = s_axi_araddr[7:2];
	if (ar_idx == `WWDT_IDX_CTRL)
		rd_byte = ctrl_reg;
	else if (ar_idx == `WWDT_IDX_STATUS)
		rd_byte = {lock_reg, 6'h00, cfg_busy};
	else
		rd_byte = 8'h00;
end

always @(posedge clk_sys)
begin
	if (rst)
	begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `WWDT_RESP_OKAY;
	end
	else
	begin
		if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h000000, rd_byte};
			s_axi_rresp <= mapped(ar_idx) ? `WWDT_RESP_OKAY : `WWDT_RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
		end
		else if (!s_axi_rvalid)
		begin
			s_axi_arready <= 1'b1;
		end
	end
end

// ----------------------------------------
// Control, lock and change guard
// ----------------------------------------
always @(posedge clk_sys)
begin
	if (rst)
	begin
		ctrl_reg <= `WWDT_CTRL_RST;
		lock_reg <= `WWDT_LOCK_RST;
		guard_cnt_reg <= 3'h0;
		boot_done_reg <= 1'b0;
	end
	else if (!boot_done_reg)
	begin
		boot_done_reg <= 1'b1;
		ctrl_reg <= boot_cfg_fuse;
		lock_reg <= (boot_cfg_fuse[`WWDT_PER_MSB:`WWDT_PER_LSB] != `WWDT_CODE_OFF);
	end
	else
	begin
		if (wr_ok && aw_idx_reg == `WWDT_IDX_GUARD && w_data_reg == UNLOCK_KEY)
			guard_cnt_reg <= `WWDT_GUARD_CYCLES;
		else if (prot_ok)
			guard_cnt_reg <= guard_cnt_reg - 3'h1;
		if (ctrl_wr)
			ctrl_reg <= w_data_reg;
		if (wr_ok && aw_idx_reg == `WWDT_IDX_STATUS && prot_ok)
		begin
			if (w_data_reg[`WWDT_LOCK_BIT])
				lock_reg <= 1'b1;
			else if (dbg_mode)
				lock_reg <= 1'b0;
		end
	end
end

// ----------------------------------------
// Watchdog counter and mode sequencer
// ----------------------------------------
always @(posedge clk_sys)
begin
	if (rst)
	begin
		act_period_reg <= `WWDT_CODE_OFF;
		act_window_reg <= `WWDT_CODE_OFF;
		state_reg <= ST_OFF;
		cnt_reg <= 14'h0000;
		dog_reset_req <= 1'b0;
	end
	else if (!boot_done_reg)
	begin
		act_period_reg <= boot_cfg_fuse[`WWDT_PER_MSB:`WWDT_PER_LSB];
		act_window_reg <= boot_cfg_fuse[`WWDT_WIN_MSB:`WWDT_WIN_LSB];
		cnt_reg <= 14'h0000;
		if (boot_cfg_fuse[`WWDT_PER_MSB:`WWDT_PER_LSB] != `WWDT_CODE_OFF)
			state_reg <= ST_NORM;
		else
			state_reg <= ST_OFF;
	end
	else if (dog_reset_req)
	begin
		state_reg <= ST_OFF;
	end
	else if (cfg_done)
	begin
		act_period_reg <= ctrl_reg[`WWDT_PER_MSB:`WWDT_PER_LSB];
		act_window_reg <= ctrl_reg[`WWDT_WIN_MSB:`WWDT_WIN_LSB];
		if (ctrl_reg[`WWDT_PER_MSB:`WWDT_PER_LSB] == `WWDT_CODE_OFF)
		begin
			state_reg <= ST_OFF;
			cnt_reg <= 14'h0000;
		end
		else if (state_reg == ST_OFF ||
			(ctrl_reg[`WWDT_WIN_MSB:`WWDT_WIN_LSB] == `WWDT_CODE_OFF) !=
			(act_window_reg == `WWDT_CODE_OFF))
		begin
			state_reg <= ST_NORM;
			cnt_reg <= 14'h0000;
		end
	end
	else if (dbg_halt)
	begin
		cnt_reg <= 14'h0000;
		if (state_reg != ST_OFF)
			state_reg <= ST_NORM;
	end
	else
	begin
		case (state_reg)
			ST_NORM, ST_OPEN:
			begin
				if (clr_done)
				begin
					cnt_reg <= 14'h0000;
					if (act_window_reg != `WWDT_CODE_OFF)
						state_reg <= ST_CLOSED;
				end
				else if (tick)
				begin
					if (cnt_reg == last_cnt)
						dog_reset_req <= 1'b1;
					else
						cnt_reg <= cnt_reg + 14'h0001;
				end
			end
			ST_CLOSED:
			begin
				if (clr_done)
					dog_reset_req <= 1'b1;
				else if (tick)
				begin
					if (cnt_reg == last_cnt)
					begin
						state_reg <= ST_OPEN;
						cnt_reg <= 14'h0000;
					end
					else
					begin
						cnt_reg <= cnt_reg + 14'h0001;
					end
				end
			end
			default:
			begin
				cnt_reg <= 14'h0000;
			end
		endcase
	end
end

endmodule // wwdt_top

`default_nettype wire

// ---- test/wwdt_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// CPU side: clear instruction and oscillator
// ----------------------------------------
module wwdt_cpu_model (
	// Clock and request
	input wire logic clk_sys,
	input wire logic clr_go,
	// Toward the watchdog
	output var logic dog_osc_clk,
	output var logic dog_clear_instr
);
	initial dog_osc_clk = 1'h0;
	initial dog_clear_instr = 1'h0;
	always #163 dog_osc_clk = ~dog_osc_clk;
	always @(posedge clk_sys) dog_clear_instr <= clr_go;
endmodule // wwdt_cpu_model
`default_nettype wire

// ---- test/wwdt_checker_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
module wwdt_checker (
	// Clock and watchdog
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic dog_osc_clk,
	input wire logic dbg_halt,
	input wire logic dog_reset_req,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	logic osc_q;
	logic [7:0] since;
	always_ff @(posedge clk_sys)
	begin
		osc_q <= dog_osc_clk;
		since <= (dog_osc_clk && !osc_q) ? 8'h00 : ((since == 8'hFF) ? since : since + 8'h01);
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	a_req_sticky: assert property (dog_reset_req |=> dog_reset_req)
		else $error("reset request dropped");
	a_req_on_tick: assert property ($rose(dog_reset_req) |-> since <= 8'h08)
		else $error("reset request not aligned to a tick");
	a_halt_quiet: assert property (dbg_halt && $past(dbg_halt) && $past(dbg_halt, 2)
		&& !$past(dog_reset_req) |-> !dog_reset_req)
		else $error("reset request while halted");
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready
		|=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response not held");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data not held");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|-> ##[1:2] s_axi_bvalid)
		else $error("write not answered");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read not answered");
	a_ar_drop: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready)
		else $error("read address ready stayed high");
	c_req: cover property ($rose(dog_reset_req));
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_halt: cover property (dbg_halt ##1 !dbg_halt);
endmodule // wwdt_checker
bind wwdt_top wwdt_checker u_chk (.clk_sys, .rst, .dog_osc_clk, .dbg_halt, .dog_reset_req,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
`default_nettype wire

// ---- test/tb_windowed_watchdog_timer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "wwdt_consts.vh"
module tb_windowed_watchdog_timer;
	localparam logic [7:0] KEY = 8'h3C; // arbitrary unlock key
	localparam logic [7:0] A_CTRL = {`WWDT_IDX_CTRL, 2'h0};
	localparam logic [7:0] A_STAT = {`WWDT_IDX_STATUS, 2'h0};
	localparam logic [7:0] A_GRD = {`WWDT_IDX_GUARD, 2'h0};
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic dbg_mode = 1'h0;
	logic dbg_halt = 1'h0;
	logic clr_go = 1'h0;
	logic awv = 1'h0, wv = 1'h0, bre = 1'h0, arv = 1'h0, rre = 1'h0;
	logic [7:0] fuse = 8'h00, awa = 8'h00, ara = 8'h00;
	logic [31:0] wd = 32'h0, d;
	logic [1:0] r;
	wire osc, clr, req, awr, wrd, bv, arr, rv;
	wire [1:0] bresp, rresp;
	wire [31:0] rdata;
	int errors = 0;
	int cmp_count = 0;
	always #10 clk_sys = ~clk_sys;
	wwdt_cpu_model cpu (.clk_sys(clk_sys), .clr_go(clr_go), .dog_osc_clk(osc),
		.dog_clear_instr(clr));
	wwdt_top #(.ADDR_W(8), .UNLOCK_KEY(KEY)) dut (.clk_sys(clk_sys), .rst(rst), .dog_osc_clk(osc),
		.boot_cfg_fuse(fuse), .dog_clear_instr(clr), .dbg_mode(dbg_mode), .dbg_halt(dbg_halt),
		.dog_reset_req(req), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
		.s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
		.s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rv), .s_axi_rready(rre));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic summarize;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic stop;
		errors++;
		summarize();
	endtask
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			errors++;
			$display("CHECK FAILED %s expected %0h seen %0h", n, e, g);
		end
	endtask
	task automatic tk(input int n);
		repeat (n * 17) @(posedge clk_sys);
	endtask
	task automatic kick;
		clr_go <= 1'h1;
		@(posedge clk_sys);
		clr_go <= 1'h0;
	endtask
	task automatic do_reset(input logic [7:0] f);
		@(posedge clk_sys);
		fuse <= f;
		rst <= 1'h1;
		repeat (8) @(posedge clk_sys);
		rst <= 1'h0;
		@(posedge clk_sys);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] v, output logic [1:0] rr);
		int n;
		n = 0;
		@(posedge clk_sys);
		awa <= a;
		wd <= {24'h0, v};
		awv <= 1'h1;
		wv <= 1'h1;
		bre <= 1'h1;
		do
		begin
			@(posedge clk_sys);
			if (awr) awv <= 1'h0;
			if (wrd) wv <= 1'h0;
			n++;
		end while (!bv && n < 50);
		bre <= 1'h0;
		rr = bresp;
		if (n >= 50) stop();
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rr);
		int n;
		n = 0;
		@(posedge clk_sys);
		ara <= a;
		arv <= 1'h1;
		rre <= 1'h1;
		do
		begin
			@(posedge clk_sys);
			if (arr) arv <= 1'h0;
			n++;
		end while (!rv && n < 50);
		rre <= 1'h0;
		v = rdata;
		rr = rresp;
		if (n >= 50) stop();
	endtask
	task automatic gw(input logic [7:0] a, input logic [7:0] v);
		wr(A_GRD, KEY, r);
		wr(a, v, r);
	endtask
	task automatic idle;
		int n;
		n = 0;
		do
		begin
			rd(A_STAT, d, r);
			n++;
		end while (d[0] !== 1'h0 && n < 100);
		if (n >= 100) stop();
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic s_regs;
		rd(A_CTRL, d, r);
		chk("ctrl reset", 32'h0, d);
		rd(A_STAT, d, r);
		chk("status reset", 32'h0, d);
		rd(8'h3C, d, r);
		chk("unmapped resp", {30'h0, `WWDT_RESP_SLVERR}, {30'h0, r});
		tk(20);
		chk("disabled req", 32'h0, {31'h0, req});
		$display("test regs done");
	endtask
	task automatic s_guard;
		wr(A_CTRL, 8'h01, r);
		chk("open resp", {30'h0, `WWDT_RESP_OKAY}, {30'h0, r});
		rd(A_CTRL, d, r);
		chk("ctrl unguarded", 32'h0, d);
		gw(A_CTRL, 8'h01);
		rd(A_STAT, d, r);
		chk("pending set", 32'h1, {31'h0, d[0]});
		idle();
		rd(A_CTRL, d, r);
		chk("ctrl guarded", 32'h1, d);
		$display("test guard done");
	endtask
	task automatic s_normal;
		repeat (4)
		begin
			kick();
			tk(4);
		end
		chk("kept alive", 32'h0, {31'h0, req});
		tk(3);
		chk("early req", 32'h0, {31'h0, req});
		tk(8);
		chk("timeout req", 32'h1, {31'h0, req});
		$display("test normal done");
	endtask
	task automatic s_window;
		do_reset(8'h00);
		gw(A_CTRL, 8'h11);
		idle();
		kick();
		tk(4);
		chk("first clear", 32'h0, {31'h0, req});
		tk(9);
		kick();
		tk(5);
		chk("open clear", 32'h0, {31'h0, req});
		kick();
		tk(6);
		chk("closed clear", 32'h1, {31'h0, req});
		$display("test window done");
	endtask
	task automatic s_resume;
		do_reset(8'h00);
		gw(A_CTRL, 8'h11);
		idle();
		kick();
		tk(5);
		chk("closed entered", 32'h0, {31'h0, req});
		dbg_halt <= 1'h1;
		tk(2);
		dbg_halt <= 1'h0;
		kick();
		tk(1);
		kick();
		tk(4);
		chk("resume clear", 32'h0, {31'h0, req});
		$display("test resume done");
	endtask
	task automatic s_lock;
		do_reset(8'h00);
		gw(A_CTRL, 8'h01);
		idle();
		gw(A_STAT, 8'h80);
		rd(A_STAT, d, r);
		chk("lock set", 32'h1, {31'h0, d[7]});
		gw(A_CTRL, 8'h00);
		rd(A_CTRL, d, r);
		chk("locked ctrl", 32'h1, d);
		gw(A_STAT, 8'h00);
		rd(A_STAT, d, r);
		chk("lock kept", 32'h1, {31'h0, d[7]});
		dbg_halt <= 1'h1;
		tk(20);
		chk("halt req", 32'h0, {31'h0, req});
		dbg_halt <= 1'h0;
		tk(5);
		chk("resume req", 32'h0, {31'h0, req});
		dbg_mode <= 1'h1;
		gw(A_STAT, 8'h00);
		rd(A_STAT, d, r);
		chk("lock cleared", 32'h0, {31'h0, d[7]});
		dbg_mode <= 1'h0;
		$display("test lock done");
	endtask
	task automatic s_fuse;
		do_reset(8'h02);
		rd(A_CTRL, d, r);
		chk("fuse ctrl", 32'h2, d);
		rd(A_STAT, d, r);
		chk("fuse lock", 32'h1, {31'h0, d[7]});
		$display("test fuse done");
	endtask
	initial
	begin
		do_reset(8'h00);
		s_regs();
		s_guard();
		s_normal();
		s_window();
		s_resume();
		s_lock();
		s_fuse();
		summarize();
	end
endmodule // tb_windowed_watchdog_timer
`default_nettype wire
